/* File: rtl/jidec_pkg.sv */
package jidec_pkg;
   // Base window: origin plus jumper offset, offset counts in steps of four
   localparam logic [15:0] BASE_ORIGIN = 16'h0200;
   localparam logic [15:0] BASE_LIMIT = 16'h0400;
   localparam logic [15:0] FACTORY_BASE = 16'h03E8;
   localparam logic [6:0] FACTORY_JUMPERS = 7'h7A;
   localparam int OFS_LSB = 2;
   localparam int OFS_BITS = 7;
   // Reset values of the captured jumpers and derived base
   localparam logic [6:0] OFFSET_RESET = 7'h7F;
   localparam logic [15:0] BASE_RESET = 16'h03FC;
   // ISA side reset levels: card not addressed, strobes idle high
   localparam logic [15:0] ISA_ADDR_RESET = 16'h0000;
   // Register byte offsets on the AXI4-Lite port
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BASE = 8'h04;
   localparam logic [7:0] REG_JUMPER = 8'h08;
   localparam logic [7:0] REG_HITS = 8'h0C;
   // Control register fields
   localparam int CTRL_ENABLE_BIT = 0;
   localparam logic CTRL_ENABLE_RESET = 1'b1;
   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: rtl/jidec_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for pins from outside the clock domain
module jidec_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input wire logic aclk, // System clock
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] pin_in, // Raw asynchronous levels
   output logic [WIDTH-1:0] sync_out // Levels after two flops
);
   // Both stages in one state word
   typedef struct packed {
      logic [WIDTH-1:0] stage1; // First stage, read only by stage2
      logic [WIDTH-1:0] stage2; // Second stage, safe to use
   } jidec_sync_state_type;

   jidec_sync_state_type state_reg;
   jidec_sync_state_type state_next;

   // Shift the pins through
   always_comb begin
      state_next.stage1 = pin_in;
      state_next.stage2 = state_reg.stage1;
   end

   // Register with constant reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= {RESET_VAL, RESET_VAL};
      end else begin
         state_reg <= state_next;
      end
   end

   assign sync_out = state_reg.stage2;
endmodule

/* File: rtl/jidec_top.sv */
`timescale 1ns/1ps
// What this block does
// - Base is 512 plus jumper offset
// - Jumpers give offset bits two to eight
// - Installed jumper reads zero, open reads one
// - Offset bits one and zero are zero
// - Base stays within 512 to 1024
// - Factory jumpers give base 1000
// - Fixed jumper addressing, no enumeration
module jidec_top
   import jidec_pkg::*;
(
   input wire logic aclk, // System clock, 125 MHz
   input wire logic aresetn, // Synchronous reset, active low
   input wire logic [6:0] offset_select_pins, // Bit0 offset_select_bit_low, bit6 high
   input wire logic [15:0] isa_addr, // Host I/O address
   input wire logic isa_aen, // Address enable, high during DMA
   input wire logic isa_ior_n, // I/O read strobe, active low
   input wire logic isa_iow_n, // I/O write strobe, active low
   output logic io_claim, // Cycle is for this card
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);
   // All block state
   typedef struct packed {
      logic [6:0] offset; // Captured jumper offset bits
      logic [15:0] base; // Decoded base address
      logic enable; // Decode enable from software
      logic claim; // Registered claim
      logic [15:0] hits; // Count of claimed cycles
      logic aw_done; // Write address held
      logic [7:0] awaddr; // Held write address
      logic w_done; // Write data held
      logic [31:0] wdata; // Held write data
      logic [3:0] wstrb; // Held strobes
      logic bvalid; // Write response pending
      logic [1:0] bresp; // Write response code
      logic rvalid; // Read data pending
      logic [31:0] rdata; // Read data
      logic [1:0] rresp; // Read response code
   } jidec_state_type;

   jidec_state_type r;
   jidec_state_type n;

   logic [6:0] jmp_s; // Jumpers after sync
   logic [15:0] addr_s; // Address after sync
   logic aen_s; // AEN after sync
   logic ior_s; // Read strobe after sync
   logic iow_s; // Write strobe after sync
   logic cycle_s; // Host I/O cycle in progress
   logic addr_hit; // Address in our four bytes

   // Pins into the clock domain; jumpers reset as open
   jidec_sync #(
      .WIDTH(26),
      .RESET_VAL({OFFSET_RESET, ISA_ADDR_RESET, 3'h7})
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in({offset_select_pins, isa_addr, isa_aen, isa_ior_n, isa_iow_n}),
      .sync_out({jmp_s, addr_s, aen_s, ior_s, iow_s})
   );

   // Host cycle and address match
   assign cycle_s = ~aen_s & (~ior_s | ~iow_s);
   assign addr_hit = (addr_s[15:OFS_LSB] == r.base[15:OFS_LSB]);

   // Channel readies
   assign s_axi_awready = ~r.aw_done & ~r.bvalid;
   assign s_axi_wready = ~r.w_done & ~r.bvalid;
   assign s_axi_arready = ~r.rvalid;

   // Next state
   always_comb begin
      n = r;
      n.offset = jmp_s;
      n.base = 16'(BASE_ORIGIN + {7'h00, r.offset, 2'h0});
      n.claim = r.enable & cycle_s & addr_hit;
      // Count each new claim
      if (n.claim & ~r.claim) begin
         n.hits = 16'(r.hits + 16'h0001);
      end
      // Take write address
      if (s_axi_awvalid & s_axi_awready) begin
         n.aw_done = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      // Take write data
      if (s_axi_wvalid & s_axi_wready) begin
         n.w_done = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      // Perform write once both held
      if (r.aw_done & r.w_done & ~r.bvalid) begin
         n.aw_done = 1'b0;
         n.w_done = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = RESP_OKAY;
         case (r.awaddr[7:2])
            REG_CTRL[7:2]: begin
               // Enable lives in byte 0
               if (r.wstrb[0]) begin
                  n.enable = r.wdata[CTRL_ENABLE_BIT];
               end
            end
            REG_BASE[7:2], REG_JUMPER[7:2], REG_HITS[7:2]: begin
               // Read-only, write ignored
               n.bresp = RESP_OKAY;
            end
            default: begin
               // Unmapped
               n.bresp = RESP_SLVERR;
            end
         endcase
      end
      // Response taken
      if (r.bvalid & s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      // Response taken
      if (r.rvalid & s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      // Read access
      if (s_axi_arvalid & s_axi_arready) begin
         n.rvalid = 1'b1;
         n.rresp = RESP_OKAY;
         case (s_axi_araddr[7:2])
            REG_CTRL[7:2]: begin
               // Enable bit
               n.rdata = {31'h00000000, r.enable};
            end
            REG_BASE[7:2]: begin
               n.rdata = {16'h0000, r.base};
            end
            REG_JUMPER[7:2]: begin
               // Raw captured jumpers
               n.rdata = {25'h0000000, r.offset};
            end
            REG_HITS[7:2]: begin
               // Claim counter
               n.rdata = {16'h0000, r.hits};
            end
            default: begin
               // Unmapped reads zero
               n.rdata = 32'h00000000;
               n.rresp = RESP_SLVERR;
            end
         endcase
      end
   end

   // State register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r <= '0;
         r.offset <= OFFSET_RESET;
         r.base <= BASE_RESET;
         r.enable <= CTRL_ENABLE_RESET;
      end else begin
         r <= n;
      end
   end

   // Outputs from flops
   assign io_claim = r.claim;
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;

   // Checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_base_sum;
      1'b1 |=> ##1 (r.base == BASE_ORIGIN + {7'h00, $past(jmp_s, 2), 2'h0});
   endproperty
   a_base_sum: assert property (p_base_sum) else $error("base not origin plus offset");

   property p_bit_map;
      1'b1 |=> (r.base[8:2] == $past(r.offset));
   endproperty
   a_bit_map: assert property (p_bit_map) else $error("offset bits misplaced");

   property p_pin_level;
      1'b1 |=> (r.offset == $past(jmp_s));
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("jumper level inverted");

   property p_low_zero;
      r.base[1:0] == 2'h0;
   endproperty
   a_low_zero: assert property (p_low_zero) else $error("base not four aligned");

   property p_range;
      (r.base >= BASE_ORIGIN) && (r.base < BASE_LIMIT);
   endproperty
   a_range: assert property (p_range) else $error("base out of range");

   property p_factory;
      (jmp_s == FACTORY_JUMPERS) [*3] |-> (r.base == FACTORY_BASE);
   endproperty
   a_factory: assert property (p_factory) else $error("factory base wrong");

   property p_fixed;
      $stable(jmp_s) [*3] |-> $stable(r.base);
   endproperty
   a_fixed: assert property (p_fixed) else $error("base moved without jumpers");

   property p_claim_cause;
      r.claim |-> $past(r.enable && !aen_s && (!ior_s || !iow_s)
         && (addr_s[15:OFS_LSB] == r.base[15:OFS_LSB]));
   endproperty
   a_claim_cause: assert property (p_claim_cause) else $error("claim without match");

   property p_claim_gate;
      (r.enable && !aen_s && (!ior_s || !iow_s)
         && (addr_s[15:OFS_LSB] == r.base[15:OFS_LSB])) |=> r.claim;
   endproperty
   a_claim_gate: assert property (p_claim_gate) else $error("matching cycle not claimed");
endmodule

/* File: sim/jidec_host_model.sv */
`timescale 1ns/1ps
// Host processor side: runs ISA I/O cycles at fixed jumper-set addresses
module jidec_host_model (
   input wire logic aclk, // System clock
   input wire logic io_claim, // Claim seen from the card
   output logic [15:0] isa_addr, // Host I/O address
   output logic isa_aen, // Address enable, high for DMA
   output logic isa_ior_n, // Read strobe, active low
   output logic isa_iow_n // Write strobe, active low
);
   // Idle bus at time zero
   initial begin
      isa_addr = 16'h0000;
      isa_aen = 1'b0;
      isa_ior_n = 1'b1;
      isa_iow_n = 1'b1;
   end
   // host uses fixed base in range
   // Strobe held five clocks so the synchronisers see it; claim sampled late
   task automatic io_cycle(input logic [15:0] a, input logic rd, input logic dma,
      output logic seen);
      @(posedge aclk);
      isa_addr <= a;
      isa_aen <= dma;
      isa_ior_n <= !rd;
      isa_iow_n <= rd;
      repeat (5) @(posedge aclk);
      seen = io_claim;
      isa_ior_n <= 1'b1;
      isa_iow_n <= 1'b1;
      isa_addr <= ~a; // Released lines do not keep the old address
      repeat (5) @(posedge aclk);
   endtask
endmodule

/* File: sim/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import jidec_pkg::*;
   logic aclk, aresetn, isa_aen, isa_ior_n, isa_iow_n, io_claim, seen; // Clock, reset, ISA
   logic [6:0] offset_select_pins; // Jumper levels
   logic [15:0] isa_addr, base_exp; // Bus address, expected base
   logic [7:0] s_axi_awaddr, s_axi_araddr; // AXI addresses
   logic [31:0] s_axi_wdata, s_axi_rdata, rd; // AXI data
   logic [3:0] s_axi_wstrb; // Byte strobes
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp; // Responses
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready; // Read handshakes
   int fail_count, checks_done, hit_exp; // Tallies
   logic [6:0] pats [5] = '{7'h00, 7'h01, 7'h40, 7'h7F, 7'h7A}; // Jumper patterns
   jidec_top dut_u (.aclk, .aresetn, .offset_select_pins, .isa_addr, .isa_aen, .isa_ior_n,
      .isa_iow_n, .io_claim, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   jidec_host_model host_u (.aclk, .io_claim, .isa_addr, .isa_aen, .isa_ior_n, .isa_iow_n);
   // Free-running clock, 8 ns
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   // Compare and tally
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Verdict and stop
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Write: each channel held until taken at a rising edge, response taken with bvalid
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Read: address held until taken, data taken with rvalid
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // Watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      end_of_test();
   end
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      offset_select_pins = FACTORY_JUMPERS;
      {fail_count, checks_done, hit_exp} = '0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_read(REG_BASE, rd, rsp);
      check("factory base", 32'h0000_03E8, rd);
      check("base resp", 32'(RESP_OKAY), 32'(rsp));
      axi_read(REG_CTRL, rd, rsp);
      check("ctrl reset", 32'h0000_0001, rd);
      axi_read(8'h10, rd, rsp);
      check("unmapped resp", 32'(RESP_SLVERR), 32'(rsp));
      check("unmapped data", 32'h0000_0000, rd);
      axi_write(8'h10, 32'h0000_0000, rsp);
      check("unmapped wresp", 32'(RESP_SLVERR), 32'(rsp));
      axi_write(REG_BASE, 32'h0000_0000, rsp);
      check("ro write resp", 32'(RESP_OKAY), 32'(rsp));
      // Each jumper pattern: base value, then claims around the window
      foreach (pats[i]) begin
         @(posedge aclk);
         offset_select_pins <= pats[i];
         repeat (6) @(posedge aclk);
         base_exp = BASE_ORIGIN + {7'h00, pats[i], 2'b00};
         axi_read(REG_BASE, rd, rsp);
         check("base", 32'(base_exp), rd);
         axi_read(REG_JUMPER, rd, rsp);
         check("jumper", 32'(pats[i]), rd);
         for (int k = -1; k <= 4; k++) begin
            host_u.io_cycle(base_exp + 16'(k), k[0], 1'b0, seen);
            check("claim", 32'(k >= 0 && k <= 3), 32'(seen));
            if (k >= 0 && k <= 3) hit_exp++;
         end
         host_u.io_cycle(base_exp, 1'b1, 1'b1, seen);
         check("dma claim", 32'h0, 32'(seen));
      end
      // Decode disabled, then enabled again
      axi_write(REG_CTRL, 32'h0000_0000, rsp);
      host_u.io_cycle(base_exp, 1'b0, 1'b0, seen);
      check("off claim", 32'h0, 32'(seen));
      axi_write(REG_CTRL, 32'h0000_0001, rsp);
      host_u.io_cycle(base_exp + 16'h0002, 1'b0, 1'b0, seen);
      check("on claim", 32'h1, 32'(seen));
      hit_exp++;
      axi_read(REG_HITS, rd, rsp);
      check("hits", 32'(hit_exp), rd);
      end_of_test();
   end
endmodule
